// [hdl/sxoc_defines.vh]
// constants for the slow crystal oscillator controller
// assumes a 10 MHz system clock and a separate power-on reset input
`ifndef SXOC_DEFINES_VH
`define SXOC_DEFINES_VH
`define SXOC_STARTUP_US 1000
`define SXOC_CLK_MHZ 10
`define SXOC_STARTUP_CYC (`SXOC_STARTUP_US * `SXOC_CLK_MHZ)
`define SXOC_CNT_W 14
`define SXOC_CNT_ONE 14'h0001
// divider: 32 source rises per 1.024 kHz period, so toggle after 16
`define SXOC_DIV_W 4
`define SXOC_DIV_ONE 4'h1
`define SXOC_KHZ_DIV 4'hf
// lost-source watchdog, a few slow-clock periods of system cycles
`define SXOC_WDG_W 11
`define SXOC_WDG_ONE 11'h001
`define SXOC_FAIL_CYC 11'h400
`define SXOC_STAT_W 2
`define SXOC_STAT_READY 0
`define SXOC_STAT_FAIL 1
`define SXOC_ST_OFF 2'h0
`define SXOC_ST_START 2'h1
`define SXOC_ST_RUN 2'h2
`endif

// [hdl/sxoc_ctrl.v]
// slow crystal oscillator controller: config, pin takeover, gated outputs, status
// assumes osc_clk_i is the analog oscillator output already sampled into clk_i domain
`timescale 1ns/1ps
`default_nettype none
`include "sxoc_defines.vh"
module sxoc_ctrl #(
   parameter [13:0] STARTUP_CYC = `SXOC_STARTUP_CYC
) (
   input wire clk_i,
   input wire srst_i,
   input wire por_i,
   input wire cfg_wr_i,
   input wire enable_i,
   input wire crystal_select_i,
   input wire full_rate_out_en_i,
   input wire khz_out_en_i,
   input wire run_in_standby_i,
   input wire on_request_run_i,
   input wire config_lock_i,
   input wire standby_i,
   input wire clk_request_i,
   input wire [1:0] irq_en_i,
   input wire [1:0] stat_clr_i,
   input wire osc_clk_i,
   input wire slow_osc_in_pin_i,
   output wire slow_osc_in_pin_oe_n_o,
   output wire slow_osc_out_pin_o,
   output wire slow_osc_out_pin_oe_n_o,
   output wire in_pin_owned_o,
   output wire out_pin_owned_o,
   output wire osc_running_o,
   output wire xtal_drive_o,
   output wire ext_path_en_o,
   output reg full_rate_clk_o,
   output reg khz_clk_o,
   output wire config_locked_o,
   output wire [1:0] status_o,
   output wire irq_o,
   output wire wake_o
);
   // configuration registers, one per control bit
   reg enable_ff;
   reg xtal_ff;
   reg en32_ff;
   reg khz_out_en_ff;
   reg stdby_ff;
   reg ondem_ff;
   reg lock_ff;

   // start-up sequencer state
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [`SXOC_CNT_W-1:0] cnt_ff;
   reg [`SXOC_CNT_W-1:0] nxt_cnt;
   reg ready_ff;
   reg nxt_ready;

   // source edge detect and the 1.024 kHz divider
   reg src_d_ff;
   reg [`SXOC_DIV_W-1:0] div_ff;
   reg khz_ff;

   // lost-source watchdog
   reg [`SXOC_WDG_W-1:0] wdg_ff;

   // sticky status flags
   reg [`SXOC_STAT_W-1:0] flag_ff;

   wire cfg_take;
   wire lock_take;
   wire run_req;
   wire src_clk;
   wire src_rise;
   wire ready_rise;
   wire wdg_expired;
   wire [`SXOC_STAT_W-1:0] stat_evt;

   // sticky flag update; an event in the clear cycle wins so none is lost
   function sxoc_sticky;
      input flag;
      input evt;
      input clr;
      begin
         sxoc_sticky = evt || (flag && !clr);
      end
   endfunction

   // output gate: only a started oscillator with its enable set passes a clock
   function sxoc_gate;
      input ready;
      input en;
      input clk;
      begin
         sxoc_gate = ready && en && clk;
      end
   endfunction

   // state decode: any state but off means the oscillator is powered
   function sxoc_is_on;
      input [1:0] st;
      begin
         sxoc_is_on = (st != `SXOC_ST_OFF);
      end
   endfunction

   // a write is taken only while the lock is open
   assign cfg_take = cfg_wr_i && !lock_ff;
   assign lock_take = cfg_take && config_lock_i;

   // lock survives system reset; only power-on reset opens it again
   always @(posedge clk_i) begin
      if (por_i) begin
         lock_ff <= 1'b0;
      end else if (lock_take) begin
         lock_ff <= 1'b1;
      end
   end

   // configuration bits; system reset returns them to off, lock or not
   always @(posedge clk_i) begin
      if (srst_i || por_i) begin
         enable_ff <= 1'b0;
         xtal_ff <= 1'b0;
         en32_ff <= 1'b0;
         khz_out_en_ff <= 1'b0;
         stdby_ff <= 1'b0;
         ondem_ff <= 1'b0;
      end else if (cfg_take) begin
         enable_ff <= enable_i;
         xtal_ff <= crystal_select_i;
         en32_ff <= full_rate_out_en_i;
         khz_out_en_ff <= khz_out_en_i;
         stdby_ff <= run_in_standby_i;
         ondem_ff <= on_request_run_i;
      end
   end

   // sleep behaviour: standby needs run_in_standby; on-request needs a consumer
   assign run_req = enable_ff &&
      (!standby_i || stdby_ff) && (!ondem_ff || clk_request_i);

   // start-up sequencer; dropping the request from any state stops at once
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         `SXOC_ST_OFF: begin
            if (run_req) begin
               nxt_state = `SXOC_ST_START;
            end
         end
         `SXOC_ST_START: begin
            if (!run_req) begin
               nxt_state = `SXOC_ST_OFF;
            end else if (cnt_ff == STARTUP_CYC) begin
               nxt_state = `SXOC_ST_RUN;
            end
         end
         `SXOC_ST_RUN: begin
            if (!run_req) begin
               nxt_state = `SXOC_ST_OFF;
            end
         end
         default: begin
            nxt_state = `SXOC_ST_OFF;
         end
      endcase
   end

   // start-up counter runs only in start, so a restart waits the full period
   always @* begin
      if (state_ff == `SXOC_ST_START) begin
         nxt_cnt = cnt_ff + `SXOC_CNT_ONE;
      end else begin
         nxt_cnt = {`SXOC_CNT_W{1'b0}};
      end
      nxt_ready = (nxt_state == `SXOC_ST_RUN);
   end

   // sequencer registers
   always @(posedge clk_i) begin
      if (srst_i || por_i) begin
         state_ff <= `SXOC_ST_OFF;
         cnt_ff <= {`SXOC_CNT_W{1'b0}};
         ready_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         ready_ff <= nxt_ready;
      end
   end

   // ready event for the status word, one cycle wide
   assign ready_rise = nxt_ready && !ready_ff;

   // pins: crystal mode owns both, external mode only the input
   assign in_pin_owned_o = enable_ff;
   assign out_pin_owned_o = enable_ff && xtal_ff;
   assign slow_osc_in_pin_oe_n_o = 1'b1; // input pin is only ever sensed
   assign slow_osc_out_pin_o = 1'b0; // crystal drive is analog, not a digital level
   assign slow_osc_out_pin_oe_n_o = 1'b1;

   // oscillator core controls
   assign osc_running_o = sxoc_is_on(state_ff);
   assign xtal_drive_o = osc_running_o && xtal_ff;
   assign ext_path_en_o = osc_running_o && !xtal_ff;
   assign src_clk = xtal_ff ? osc_clk_i : slow_osc_in_pin_i;

   // source edge detector; idle level low matches a stopped source
   assign src_rise = src_clk && !src_d_ff;
   always @(posedge clk_i) begin
      if (srst_i || por_i) begin
         src_d_ff <= 1'b0;
      end else begin
         src_d_ff <= src_clk;
      end
   end

   // 1.024 kHz: toggle every 16 source rises, one full period per 32
   always @(posedge clk_i) begin
      if (srst_i || por_i) begin
         div_ff <= {`SXOC_DIV_W{1'b0}};
         khz_ff <= 1'b0;
      end else if (src_rise && ready_ff) begin
         div_ff <= div_ff + `SXOC_DIV_ONE; // wraps after the last count
         if (div_ff == `SXOC_KHZ_DIV) begin
            khz_ff <= !khz_ff;
         end
      end
   end

   // gated outputs are registered, so a gate change lands on a clock edge but can still cut a source high phase short
   always @(posedge clk_i) begin
      if (srst_i || por_i) begin
         full_rate_clk_o <= 1'b0;
         khz_clk_o <= 1'b0;
      end else begin
         full_rate_clk_o <= sxoc_gate(ready_ff, en32_ff, src_clk);
         khz_clk_o <= sxoc_gate(ready_ff, khz_out_en_ff, khz_ff);
      end
   end

   // lost-source watchdog: armed only after start-up, since a crystal is
   // silent while it builds up; it saturates instead of wrapping
   assign wdg_expired = (wdg_ff == `SXOC_FAIL_CYC);
   always @(posedge clk_i) begin
      if (srst_i || por_i) begin
         wdg_ff <= {`SXOC_WDG_W{1'b0}};
      end else if (!ready_ff || src_rise) begin
         wdg_ff <= {`SXOC_WDG_W{1'b0}};
      end else if (!wdg_expired) begin
         wdg_ff <= wdg_ff + `SXOC_WDG_ONE;
      end
   end

   // status events gathered into one word
   assign stat_evt[`SXOC_STAT_READY] = ready_rise;
   assign stat_evt[`SXOC_STAT_FAIL] = wdg_expired;

   // sticky status; a new event wins over a same-cycle clear
   always @(posedge clk_i) begin
      if (srst_i || por_i) begin
         flag_ff <= {`SXOC_STAT_W{1'b0}};
      end else begin
         flag_ff[`SXOC_STAT_READY] <= sxoc_sticky(flag_ff[`SXOC_STAT_READY],
            stat_evt[`SXOC_STAT_READY], stat_clr_i[`SXOC_STAT_READY]);
         flag_ff[`SXOC_STAT_FAIL] <= sxoc_sticky(flag_ff[`SXOC_STAT_FAIL],
            stat_evt[`SXOC_STAT_FAIL], stat_clr_i[`SXOC_STAT_FAIL]);
      end
   end

   // status, interrupt and wake outputs
   assign config_locked_o = lock_ff;
   assign status_o = {flag_ff[`SXOC_STAT_FAIL], ready_ff};
   assign irq_o = |(flag_ff & irq_en_i);
   // wake is only meaningful in standby; elsewhere the interrupt alone serves
   assign wake_o = standby_i && irq_o;
endmodule // sxoc_ctrl
`default_nettype wire

// [testbench/sxoc_ctrl_checker.sv]
// checker on sxoc_ctrl ports: pin takeover, lock, gating, ready timing
// assumes a bind into sxoc_ctrl with ports of the same names
`timescale 1ns/1ps
`default_nettype none
module sxoc_ctrl_checker #(parameter int STARTUP_CYC = 8) (
   input wire clk_i, srst_i, por_i, cfg_wr_i, enable_i, crystal_select_i, config_lock_i,
   input wire full_rate_out_en_i, khz_out_en_i, in_pin_owned_o, out_pin_owned_o,
   input wire osc_running_o, full_rate_clk_o, khz_clk_o, config_locked_o,
   input wire [1:0] status_o);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i || por_i);
   wire wr_ok = cfg_wr_i && !config_locked_o; // write let through by the lock
   pin_own_a: assert property (wr_ok |=> {in_pin_owned_o, out_pin_owned_o} ==
      $past({enable_i, enable_i & crystal_select_i})) else $error("pin ownership");
   lock_set_a: assert property (wr_ok && config_lock_i |=> config_locked_o)
      else $error("lock set");
   lock_hold_a: assert property (config_locked_o |=>
      config_locked_o && $stable(in_pin_owned_o)) else $error("lock held");
   osc_stop_a: assert property (!in_pin_owned_o [*2] |-> !osc_running_o)
      else $error("osc stop");
   ready_clr_a: assert property (!in_pin_owned_o |-> ##2 !status_o[0])
      else $error("ready clear");
   ready_late_a: assert property ($rose(status_o[0]) |->
      $past(osc_running_o, STARTUP_CYC + 1)) else $error("ready early");
   full_gate_a: assert property (wr_ok && !full_rate_out_en_i |=> ##1 !full_rate_clk_o)
      else $error("full gate");
   khz_gate_a: assert property (wr_ok && !khz_out_en_i ##1 !cfg_wr_i
      |=> ##1 $stable(khz_clk_o)) else $error("khz gate");
   cover property ($rose(status_o[0]));
   cover property (config_locked_o && cfg_wr_i);
   cover property (in_pin_owned_o && !out_pin_owned_o);
endmodule // sxoc_ctrl_checker
`default_nettype wire

// [testbench/sxoc_osc_model.sv]
// crystal and external clock source on the slow oscillator pins
// assumes a system clock twice the rate of the modelled oscillator
`timescale 1ns/1ps
`default_nettype none
module sxoc_osc_model (input wire logic clk_i, xtal_drive_i, output logic osc_o, pin_o);
   initial {osc_o, pin_o} = 2'h0;
   // crystal dies without drive, so no stale swing hides a missing enable
   always @(negedge clk_i) {osc_o, pin_o} <= {xtal_drive_i & ~osc_o, ~pin_o};
endmodule // sxoc_osc_model
`default_nettype wire

// [testbench/sxoc_ctrl_tb.sv]
// bench for sxoc_ctrl: config writes, takeover, gating, standby, lock
// assumes the oscillator model on the clock inputs and a start-up count of 8
`timescale 1ns/1ps
`default_nettype none
module sxoc_ctrl_tb;
   logic clk_i, srst_i, por_i, cfg_wr_i, enable_i, crystal_select_i, full_rate_out_en_i;
   logic khz_out_en_i, run_in_standby_i, on_request_run_i, config_lock_i, standby_i;
   logic clk_request_i, osc_clk_i, slow_osc_in_pin_i, slow_osc_in_pin_oe_n_o, irq_o;
   logic slow_osc_out_pin_o, slow_osc_out_pin_oe_n_o, in_pin_owned_o, out_pin_owned_o;
   logic osc_running_o, xtal_drive_o, ext_path_en_o, full_rate_clk_o, khz_clk_o, wake_o;
   logic config_locked_o;
   logic [1:0] irq_en_i, stat_clr_i, status_o;
   int errors, checks, cyc, ft, kt;
   sxoc_ctrl #(.STARTUP_CYC(14'h8)) DUT (.*);
   sxoc_osc_model M (.clk_i(clk_i), .xtal_drive_i(xtal_drive_o), .osc_o(osc_clk_i),
      .pin_o(slow_osc_in_pin_i));
   task automatic chk(input string n, input logic [1:0] e, g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // idle cycle after each write keeps the strobe from toggling twice at once
   task automatic cfg(input logic [6:0] v);
      {enable_i, crystal_select_i, full_rate_out_en_i, khz_out_en_i, run_in_standby_i,
         on_request_run_i, config_lock_i} = v;
      cfg_wr_i = 1'b1;
      w(1);
      cfg_wr_i = 1'b0;
      w(1);
   endtask
   task automatic report_and_stop;
      if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // hang guard well above the few hundred cycles the run needs
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 3000) begin
         errors++;
         report_and_stop;
      end
   end
   always @(full_rate_clk_o) ft++;
   always @(khz_clk_o) kt++;
   initial begin
      {cfg_wr_i, run_in_standby_i, on_request_run_i, config_lock_i, standby_i} = 5'h0;
      {enable_i, crystal_select_i, full_rate_out_en_i, khz_out_en_i, clk_request_i} = 5'h0;
      {stat_clr_i, irq_en_i, srst_i, por_i} = 6'h07;
      w(5);
      {srst_i, por_i} = 2'h0;
      chk("own", 2'h0, {in_pin_owned_o, out_pin_owned_o});
      cfg(7'h78);
      chk("own", 2'h3, {in_pin_owned_o, out_pin_owned_o});
      w(8);
      chk("rdy", 2'h0, status_o);
      w(1);
      chk("rdy", 2'h1, status_o);
      w(1);
      chk("irq", 2'h1, {1'b0, irq_o});
      irq_en_i = 2'h0;
      {ft, kt} = 64'h0;
      w(200);
      chk("irq", 2'h0, {1'b0, irq_o});
      chk("tog", 2'h3, {ft > 0, kt > 0});
      chk("kdiv", 2'h1, {1'b0, kt == 6 || kt == 7});
      cfg(7'h60);
      {ft, kt} = 64'h0;
      w(100);
      chk("tog", 2'h0, {ft > 0, kt > 0});
      cfg(7'h40);
      w(1);
      chk("own", 2'h2, {in_pin_owned_o, out_pin_owned_o});
      chk("path", 2'h1, {xtal_drive_o, ext_path_en_o});
      standby_i = 1'b1;
      irq_en_i = 2'h1;
      w(3);
      chk("run", 2'h0, {1'b0, osc_running_o});
      chk("wake", 2'h1, {1'b0, wake_o});
      stat_clr_i = 2'h1;
      w(1);
      stat_clr_i = 2'h0;
      chk("wake", 2'h0, {status_o[1], wake_o});
      cfg(7'h44);
      w(1);
      chk("run", 2'h1, {1'b0, osc_running_o});
      cfg(7'h04);
      w(1);
      chk("run", 2'h0, {status_o[0], osc_running_o});
      standby_i = 1'b0;
      cfg(7'h41);
      cfg(7'h00);
      chk("lock", 2'h3, {config_locked_o, in_pin_owned_o});
      srst_i = 1'b1;
      w(1);
      {srst_i, por_i} = 2'h1;
      chk("lock", 2'h1, {1'b0, config_locked_o});
      w(1);
      por_i = 1'b0;
      chk("lock", 2'h0, {1'b0, config_locked_o});
      report_and_stop;
   end
endmodule // sxoc_ctrl_tb
bind sxoc_ctrl sxoc_ctrl_checker #(.STARTUP_CYC(STARTUP_CYC)) chk_u (.*);
`default_nettype wire
